// >>> hdl/bmr_alarm_latch.sv
// Purpose: one latched alarm bit
// Assumes: condition and clear come from logic on the same clock
// Notes:   a clear cannot drop a bit whose condition is still present
`timescale 1ns/100ps
module bmr_alarm_latch (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_cond,
  input  wire logic i_clear,
  output logic      o_latched
);
  import bmr_pkg::*;

  typedef struct packed {
    logic latched;
  } bmr_latch_t;

  bmr_latch_t s_reg;
  bmr_latch_t s_next;

  always_comb begin
    s_next = s_reg;
    if (i_cond) begin
      s_next.latched = 1'b1;
    end else if (i_clear) begin
      s_next.latched = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_latched = s_reg.latched;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  clear_drops_a: assert property (i_clear && !i_cond |=> !o_latched)
    else $error("alarm stayed latched after clear");
  clear_holds_a: assert property (i_cond ##0 i_clear |=> o_latched)
    else $error("alarm cleared while condition present");

endmodule // bmr_alarm_latch

// >>> hdl/bmr_pkg.sv
// Purpose: constants and types of the battery point responder
// Assumes: one 16-bit point per register address, 50 MHz reference clock
// Notes:   all offsets are point addresses on the register request port
package bmr_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_TIME_MS    = 1000;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_TIME_MS;

  // implemented points
  localparam logic [15:0] ADDR_DEVICE_HB     = 16'h9c96;
  localparam logic [15:0] ADDR_CONTROLLER_HB = 16'h9c97;
  localparam logic [15:0] ADDR_ALARM_CLEAR   = 16'h9c98;
  localparam logic [15:0] ADDR_FAULT_BITS    = 16'h9ca5;
  localparam logic [15:0] ADDR_DC_VOLTAGE    = 16'h9ca9;
  localparam logic [15:0] ADDR_CHARGE_LIM    = 16'h9caa;
  localparam logic [15:0] ADDR_DISCHARGE_LIM = 16'h9cab;
  localparam logic [15:0] ADDR_STACK_CMD     = 16'h9cae;
  localparam logic [15:0] ADDR_TOTAL_CUR     = 16'h9cbf;

  // scale-factor points
  localparam logic [15:0] ADDR_SF_LIMIT      = 16'h9cb0;
  localparam logic [15:0] ADDR_SF_VOLTAGE    = 16'h9cb2;
  localparam logic [15:0] ADDR_SF_TOTAL_CUR  = 16'h9cc2;

  // unimplemented points of non-default type
  localparam logic [15:0] ADDR_UNIMP_S16_A   = 16'h9cb1;
  localparam logic [15:0] ADDR_UNIMP_S16_B   = 16'h9cb3;
  localparam logic [15:0] ADDR_CYCLE_CT_HI   = 16'h9ca0;
  localparam logic [15:0] ADDR_CYCLE_CT_LO   = 16'h9ca1;
  localparam logic [15:0] ADDR_PWR_REQ_HI    = 16'h9cac;
  localparam logic [15:0] ADDR_PWR_REQ_LO    = 16'h9cad;
  localparam logic [15:0] ADDR_STR_EVT2_HI   = 16'h9cd1;
  localparam logic [15:0] ADDR_STR_EVT2_LO   = 16'h9cd2;

  localparam logic [15:0] MAP_FIRST          = 16'h9c86;
  localparam logic [15:0] MAP_LAST           = 16'h9cd5;

  localparam logic [15:0] UNIMP_S16          = 16'h8000;
  localparam logic [15:0] UNIMP_U16          = 16'hffff;
  localparam logic [31:0] UNIMP_S32          = 32'h80000000;
  localparam logic [31:0] UNIMP_U32          = 32'hffffffff;

  // signed base-10 exponents, two's complement
  localparam logic [15:0] SF_VOLTAGE         = 16'hfffe;
  localparam logic [15:0] SF_LIMIT           = 16'hffff;
  localparam logic [15:0] SF_TOTAL_CUR       = 16'hffff;

  localparam logic [15:0] ALARM_CLEAR_VAL    = 16'h0001;
  localparam logic [15:0] CMD_DISCONNECT     = 16'h0000;
  localparam logic [15:0] CMD_CONNECT        = 16'h0001;
  localparam logic [4:0]  RO_CONN_MAX        = 5'h10;
  localparam int unsigned ALARM_BITS         = 16;
  localparam int unsigned WDOG_ALARM_BIT     = 0;

  typedef enum logic [2:0] {
    PK_IMPL   = 3'h0,
    PK_U16    = 3'h1,
    PK_S16    = 3'h2,
    PK_U32_HI = 3'h3,
    PK_U32_LO = 3'h4,
    PK_S32_HI = 3'h5,
    PK_S32_LO = 3'h6,
    PK_NONE   = 3'h7
  } bmr_kind_t;

  typedef enum logic [1:0] {
    ST_OPEN      = 2'h0,
    ST_PRECHARGE = 2'h1,
    ST_CLOSED    = 2'h2
  } bmr_stack_t;

endpackage : bmr_pkg

// >>> hdl/bmr_responder.sv
// Contract
// - unimplemented 16-bit reads give 0x8000 signed, 0xFFFF unsigned or enumerated.
// - unimplemented 32-bit reads give 0x80000000 signed, all ones unsigned.
// - writes to unimplemented or non-writable points answer with a write error.
// - reading the alarm-clear point returns the unimplemented sentinel.
// - a fixed set of points in models 801 to 803 reads as unimplemented.
// - scale-factor points hold signed base-ten exponents of their values.
// - scale-factor values are constants and never change.
// - loss of controller communication disconnects the stacks.
// - only one read/write connection on port 502 is accepted.
// - grid variant adds read-only connections on port 11503.
// - device heartbeat counter at 40086 increments once per second.
// - controller heartbeat writes restart a watchdog; timeout faults and opens contactors.
// - writing 1 to the alarm-clear point clears latched alarms.
// - an alarm whose condition persists stays latched after a clear.
// - the stack command point connects or disconnects all stacks together.
// - when configured, precharge is sequenced automatically on connect.
// - fault bits, DC voltage and total DC current are readable.
// - charge and discharge current limits are readable with scale factors.
// - registers are 16 bits; partial reads of wider points are errors.
//
// Purpose: point map responder of a battery controller behind a Modbus engine
// Assumes: framing is done upstream; one register per request; inputs on i_ref_clk
// Notes:   answers come one cycle after each request
`timescale 1ns/100ps
module bmr_responder #(
  parameter int unsigned TICK_CYCLES = bmr_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_req_valid,
  input  wire logic                          i_req_write,
  input  wire logic [15:0]                   i_req_addr,
  input  wire logic [15:0]                   i_req_wdata,
  input  wire logic                          i_req_first,
  input  wire logic                          i_req_last,
  input  wire logic                          i_req_port_ro,
  input  wire logic                          i_conn_open,
  input  wire logic                          i_conn_close,
  input  wire logic                          i_conn_port_ro,
  input  wire logic                          i_grid_variant,
  input  wire logic                          i_wdog_enable,
  input  wire logic [15:0]                   i_wdog_period_s,
  input  wire logic [bmr_pkg::ALARM_BITS-1:0] i_alarm_cond,
  input  wire logic [15:0]                   i_dc_voltage,
  input  wire logic [15:0]                   i_charge_limit,
  input  wire logic [15:0]                   i_discharge_limit,
  input  wire logic [15:0]                   i_dc_current,
  input  wire logic                          i_precharge_cfg,
  input  wire logic                          i_precharge_done,
  output logic                               o_rsp_valid,
  output logic                               o_rsp_error,
  output logic [15:0]                        o_rsp_data,
  output logic                               o_conn_grant,
  output logic                               o_conn_deny,
  output logic                               o_contactor_close,
  output logic                               o_precharge_en,
  output logic                               o_stack_fault,
  output logic [bmr_pkg::ALARM_BITS-1:0]      o_alarm_latched
);
  import bmr_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  typedef struct packed {
    logic        rsp_valid;
    logic        rsp_error;
    logic [15:0] rsp_data;
    logic [31:0] tick_cnt;
    logic [15:0] hb_cnt;
    logic [15:0] ctl_hb;
    logic [15:0] wd_secs;
    logic        wd_expired;
    logic        clr_pulse;
    logic [15:0] op_cmd;
    bmr_stack_t  stack_st;
    logic        rw_conn;
    logic [4:0]  ro_conns;
    logic        conn_grant;
    logic        conn_deny;
  } bmr_state_t;

  bmr_state_t                s_reg;
  bmr_state_t                s_next;
  bmr_kind_t                 kind;
  logic                      tick;
  logic                      writable;
  logic                      hb_write;
  logic [16:0]               wd_inc;
  logic [ALARM_BITS-1:0]     alarm_cond;
  logic [ALARM_BITS-1:0]     alarm_latched;

  // the unimplemented set and the types of its points
  function automatic bmr_kind_t point_kind(input logic [15:0] a);
    bmr_kind_t k;
    k = PK_U16;
    if (a < MAP_FIRST || a > MAP_LAST) begin
      k = PK_NONE;
    end else begin
      case (a)
        ADDR_DEVICE_HB, ADDR_CONTROLLER_HB, ADDR_FAULT_BITS,
        ADDR_DC_VOLTAGE, ADDR_CHARGE_LIM, ADDR_DISCHARGE_LIM,
        ADDR_STACK_CMD, ADDR_TOTAL_CUR, ADDR_SF_LIMIT,
        ADDR_SF_VOLTAGE, ADDR_SF_TOTAL_CUR: k = PK_IMPL;
        ADDR_ALARM_CLEAR:                   k = PK_U16;
        ADDR_UNIMP_S16_A, ADDR_UNIMP_S16_B: k = PK_S16;
        ADDR_CYCLE_CT_HI, ADDR_STR_EVT2_HI: k = PK_U32_HI;
        ADDR_CYCLE_CT_LO, ADDR_STR_EVT2_LO: k = PK_U32_LO;
        ADDR_PWR_REQ_HI:                    k = PK_S32_HI;
        ADDR_PWR_REQ_LO:                    k = PK_S32_LO;
        default:                            k = PK_U16;
      endcase
    end
    return k;
  endfunction

  assign kind     = point_kind(i_req_addr);
  assign tick     = (s_reg.tick_cnt == TICK_LAST);
  assign writable = (i_req_addr == ADDR_CONTROLLER_HB) || (i_req_addr == ADDR_ALARM_CLEAR) ||
                    (i_req_addr == ADDR_STACK_CMD);
  assign hb_write = i_req_valid && i_req_write && !i_req_port_ro &&
                    (i_req_addr == ADDR_CONTROLLER_HB);
  assign wd_inc   = {1'b0, s_reg.wd_secs} + 17'h00001;

  // the watchdog timeout counts as a latched alarm while it persists
  always_comb begin
    alarm_cond                 = i_alarm_cond;
    alarm_cond[WDOG_ALARM_BIT] = i_alarm_cond[WDOG_ALARM_BIT] | s_reg.wd_expired;
  end

  genvar g;
  generate
    for (g = 0; g < ALARM_BITS; g++) begin : g_alarm
      bmr_alarm_latch u_latch (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_cond    (alarm_cond[g]),
        .i_clear   (s_reg.clr_pulse),
        .o_latched (alarm_latched[g])
      );
    end
  endgenerate

  always_comb begin
    s_next            = s_reg;
    s_next.rsp_valid  = 1'b0;
    s_next.rsp_error  = 1'b0;
    s_next.clr_pulse  = 1'b0;
    s_next.conn_grant = 1'b0;
    s_next.conn_deny  = 1'b0;

    s_next.tick_cnt = tick ? 32'h00000000 : s_reg.tick_cnt + 32'h00000001;
    if (tick) begin
      s_next.hb_cnt = s_reg.hb_cnt + 16'h0001;
    end

    // supervision off means no fault can ever be raised by it
    if (!i_wdog_enable) begin
      s_next.wd_secs    = 16'h0000;
      s_next.wd_expired = 1'b0;
    end else if (hb_write) begin
      s_next.wd_secs    = 16'h0000;
      s_next.wd_expired = 1'b0;
    end else if (tick && !s_reg.wd_expired) begin
      s_next.wd_secs = wd_inc[15:0];
      if (wd_inc >= {1'b0, i_wdog_period_s}) begin
        s_next.wd_expired = 1'b1;
      end
    end

    if (i_req_valid) begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_data  = 16'h0000;
      if (i_req_write) begin
        if (i_req_port_ro) begin
          s_next.rsp_error = 1'b1;
        end else if (!writable) begin
          s_next.rsp_error = 1'b1;
        end else if (i_req_addr == ADDR_CONTROLLER_HB) begin
          s_next.ctl_hb = i_req_wdata;
        end else if (i_req_addr == ADDR_ALARM_CLEAR) begin
          s_next.clr_pulse = (i_req_wdata == ALARM_CLEAR_VAL);
        end else if (i_req_wdata == CMD_CONNECT || i_req_wdata == CMD_DISCONNECT) begin
          s_next.op_cmd = i_req_wdata;
        end else begin
          s_next.rsp_error = 1'b1;
        end
      end else begin
        case (kind)
          PK_NONE: s_next.rsp_error = 1'b1;
          PK_U16:  s_next.rsp_data  = UNIMP_U16;
          PK_S16:  s_next.rsp_data  = UNIMP_S16;
          PK_U32_HI: begin
            s_next.rsp_error = i_req_last;
            s_next.rsp_data  = i_req_last ? 16'h0000 : UNIMP_U32[31:16];
          end
          PK_U32_LO: begin
            s_next.rsp_error = i_req_first;
            s_next.rsp_data  = i_req_first ? 16'h0000 : UNIMP_U32[15:0];
          end
          PK_S32_HI: begin
            s_next.rsp_error = i_req_last;
            s_next.rsp_data  = i_req_last ? 16'h0000 : UNIMP_S32[31:16];
          end
          PK_S32_LO: begin
            s_next.rsp_error = i_req_first;
            s_next.rsp_data  = i_req_first ? 16'h0000 : UNIMP_S32[15:0];
          end
          default: begin
            case (i_req_addr)
              ADDR_DEVICE_HB:     s_next.rsp_data = s_reg.hb_cnt;
              ADDR_CONTROLLER_HB: s_next.rsp_data = s_reg.ctl_hb;
              ADDR_FAULT_BITS:    s_next.rsp_data = alarm_latched;
              ADDR_DC_VOLTAGE:    s_next.rsp_data = i_dc_voltage;
              ADDR_TOTAL_CUR:     s_next.rsp_data = i_dc_current;
              ADDR_CHARGE_LIM:    s_next.rsp_data = i_charge_limit;
              ADDR_DISCHARGE_LIM: s_next.rsp_data = i_discharge_limit;
              ADDR_STACK_CMD:     s_next.rsp_data = s_reg.op_cmd;
              ADDR_SF_VOLTAGE:    s_next.rsp_data = SF_VOLTAGE;
              ADDR_SF_LIMIT:      s_next.rsp_data = SF_LIMIT;
              ADDR_SF_TOTAL_CUR:  s_next.rsp_data = SF_TOTAL_CUR;
              default:            s_next.rsp_data = UNIMP_U16;
            endcase
          end
        endcase
      end
    end

    // a timeout overrides any pending connect so stacks cannot reclose by themselves
    if (s_reg.wd_expired) begin
      s_next.op_cmd   = CMD_DISCONNECT;
      s_next.stack_st = ST_OPEN;
    end else begin
      case (s_reg.stack_st)
        ST_OPEN: begin
          if (s_reg.op_cmd == CMD_CONNECT) begin
            s_next.stack_st = i_precharge_cfg ? ST_PRECHARGE : ST_CLOSED;
          end
        end
        ST_PRECHARGE: begin
          if (s_reg.op_cmd != CMD_CONNECT) begin
            s_next.stack_st = ST_OPEN;
          end else if (i_precharge_done) begin
            s_next.stack_st = ST_CLOSED;
          end
        end
        ST_CLOSED: begin
          if (s_reg.op_cmd != CMD_CONNECT) begin
            s_next.stack_st = ST_OPEN;
          end
        end
        default: s_next.stack_st = ST_OPEN;
      endcase
    end

    // admission; an open in the same cycle as a close is served and the close is dropped
    if (i_conn_open) begin
      if (!i_conn_port_ro) begin
        if (s_reg.rw_conn) begin
          s_next.conn_deny = 1'b1;
        end else begin
          s_next.rw_conn    = 1'b1;
          s_next.conn_grant = 1'b1;
        end
      end else if (i_grid_variant && s_reg.ro_conns < RO_CONN_MAX) begin
        s_next.ro_conns   = s_reg.ro_conns + 5'h01;
        s_next.conn_grant = 1'b1;
      end else begin
        s_next.conn_deny = 1'b1;
      end
    end else if (i_conn_close) begin
      if (!i_conn_port_ro) begin
        s_next.rw_conn = 1'b0;
      end else if (s_reg.ro_conns != 5'h00) begin
        s_next.ro_conns = s_reg.ro_conns - 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rsp_valid       = s_reg.rsp_valid;
  assign o_rsp_error       = s_reg.rsp_error;
  assign o_rsp_data        = s_reg.rsp_data;
  assign o_conn_grant      = s_reg.conn_grant;
  assign o_conn_deny       = s_reg.conn_deny;
  assign o_contactor_close = (s_reg.stack_st == ST_CLOSED);
  assign o_precharge_en    = (s_reg.stack_st == ST_PRECHARGE);
  assign o_stack_fault     = s_reg.wd_expired;
  assign o_alarm_latched   = alarm_latched;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  unimp_s16_a: assert property (i_req_valid && !i_req_write && kind == PK_S16 |=>
      o_rsp_valid && !o_rsp_error && o_rsp_data == 16'h8000)
    else $error("signed 16-bit sentinel wrong");
  unimp_u16_a: assert property (i_req_valid && !i_req_write && kind == PK_U16 |=>
      !o_rsp_error && o_rsp_data == 16'hffff)
    else $error("unsigned 16-bit sentinel wrong");
  unimp_s32_a: assert property (
      (i_req_valid && !i_req_write && kind == PK_S32_HI && !i_req_last |=>
       !o_rsp_error && o_rsp_data == 16'h8000) and
      (i_req_valid && !i_req_write && kind == PK_S32_LO && !i_req_first |=>
       !o_rsp_error && o_rsp_data == 16'h0000))
    else $error("signed 32-bit sentinel wrong");
  bad_write_a: assert property (i_req_valid && i_req_write && !writable |=>
      o_rsp_valid && o_rsp_error)
    else $error("write to non-writable point accepted");
  clear_read_a: assert property (i_req_valid && !i_req_write &&
      i_req_addr == ADDR_ALARM_CLEAR |=> o_rsp_data == 16'hffff)
    else $error("alarm clear point readable");
  sf_fixed_a: assert property (i_req_valid && !i_req_write &&
      i_req_addr == ADDR_SF_VOLTAGE |=> o_rsp_data == 16'hfffe)
    else $error("voltage scale factor changed");
  wdog_open_a: assert property ($rose(s_reg.wd_expired) |-> ##1
      !o_contactor_close [*3])
    else $error("contactor not opened after timeout");
  one_rw_a: assert property (i_conn_open && !i_conn_port_ro && s_reg.rw_conn |=>
      o_conn_deny && !o_conn_grant)
    else $error("second read/write connection granted");
  ro_write_a: assert property (i_req_valid && i_req_write && i_req_port_ro |=>
      o_rsp_error)
    else $error("write over read-only port accepted");
  hb_step_a: assert property (tick |=> s_reg.hb_cnt == $past(s_reg.hb_cnt) + 16'h0001)
    else $error("heartbeat counter did not step");
  hb_restart_a: assert property (hb_write && i_wdog_enable |=>
      s_reg.wd_secs == 16'h0000 && !o_stack_fault)
    else $error("heartbeat write did not restart watchdog");
  wdog_off_a: assert property (!i_wdog_enable |=> !o_stack_fault)
    else $error("fault raised with watchdog disabled");
  partial_a: assert property (i_req_valid && !i_req_write && i_req_last &&
      (kind == PK_U32_HI || kind == PK_S32_HI) |=> o_rsp_error)
    else $error("partial read of wide point accepted");

  connect_c: cover property (o_precharge_en ##[1:20] o_contactor_close);
  timeout_c: cover property ($rose(o_stack_fault));
  clear_c:   cover property (s_reg.clr_pulse);
  deny_c:    cover property (o_conn_deny);

endmodule // bmr_responder

// >>> verification/battery_modbus_point_responder_tb_top.sv
// Purpose: self-checking bench of the battery point responder
// Assumes: a tick of TICKS cycles stands in for one second
// Notes:   register traffic goes through the site master model
`timescale 1ns/100ps
module battery_modbus_point_responder_tb_top;
  import bmr_pkg::*;
  localparam int unsigned TICKS = 20;
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_req_port_ro = 1'b0, i_conn_close = 1'b0;
  logic        i_conn_open = 1'b0, i_conn_port_ro = 1'b0, i_grid_variant = 1'b0;
  logic        i_wdog_enable = 1'b0, i_precharge_cfg = 1'b0, i_precharge_done = 1'b0;
  logic [15:0] i_alarm_cond = 16'h0000, i_wdog_period_s = 16'h0002;
  logic [15:0] i_dc_voltage = 16'h0000, i_charge_limit = 16'h0000;
  logic [15:0] i_discharge_limit = 16'h0000, i_dc_current = 16'h0000;
  logic        i_req_valid, i_req_write, i_req_first, i_req_last, o_rsp_valid, o_rsp_error;
  logic [15:0] i_req_addr, i_req_wdata, o_rsp_data, o_alarm_latched, hb_first;
  logic        o_conn_grant, o_conn_deny, o_contactor_close, o_precharge_en, o_stack_fault;
  logic [15:0] ra [10] = '{ADDR_ALARM_CLEAR, ADDR_UNIMP_S16_A, ADDR_SF_VOLTAGE, ADDR_SF_LIMIT,
    ADDR_SF_TOTAL_CUR, 16'h9c9a, ADDR_DC_VOLTAGE, ADDR_CHARGE_LIM, ADDR_DISCHARGE_LIM,
    ADDR_TOTAL_CUR};
  logic [15:0] rx [10];
  int          errors = 0, checked = 0, cycles = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  bmr_responder #(.TICK_CYCLES(TICKS)) u_dut (
    .i_ref_clk, .i_sys_rst, .i_req_valid, .i_req_write, .i_req_addr, .i_req_wdata,
    .i_req_first, .i_req_last, .i_req_port_ro, .i_conn_open, .i_conn_close,
    .i_conn_port_ro, .i_grid_variant, .i_wdog_enable, .i_wdog_period_s, .i_alarm_cond,
    .i_dc_voltage, .i_charge_limit, .i_discharge_limit, .i_dc_current, .i_precharge_cfg,
    .i_precharge_done, .o_rsp_valid, .o_rsp_error, .o_rsp_data, .o_conn_grant, .o_conn_deny,
    .o_contactor_close, .o_precharge_en, .o_stack_fault, .o_alarm_latched);
  bmr_site_master u_mst (.i_ref_clk, .i_rsp_valid(o_rsp_valid), .i_rsp_error(o_rsp_error),
    .i_rsp_data(o_rsp_data), .o_req_valid(i_req_valid), .o_req_write(i_req_write),
    .o_req_addr(i_req_addr), .o_req_wdata(i_req_wdata), .o_req_first(i_req_first),
    .o_req_last(i_req_last));
  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chb(input string what, input logic exp, got);
    chk(what, {15'h0, exp}, {15'h0, got});
  endtask
  // heartbeat expected after n edges, one step per whole tick
  function automatic logic [15:0] hb_after(input logic [15:0] h, input int n);
    return h + 16'(n / TICKS);
  endfunction
  // data is zero on writes and errors, so it is always compared
  task automatic acc(input logic w, input logic [15:0] a, d, input logic f, l, e,
                     input logic [15:0] x);
    u_mst.xfer(w, a, d, f, l);
    chb("rsp_valid", 1'b1, u_mst.got_valid);
    chb("rsp_error", e, u_mst.got_error);
    chk("rsp_data", x, u_mst.got_data);
  endtask
  task automatic conn(input logic ro, g);
    @(posedge i_ref_clk);
    i_conn_open <= 1'b1;
    i_conn_port_ro <= ro;
    @(posedge i_ref_clk);
    i_conn_open <= 1'b0;
    #1;
    chb("conn_grant", g, o_conn_grant);
    chb("conn_deny", !g, o_conn_deny);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h4fea5c49));
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    repeat (2) begin
      @(posedge i_ref_clk);
      i_dc_voltage <= 16'($urandom);
      i_charge_limit <= 16'($urandom);
      i_discharge_limit <= 16'($urandom);
      i_dc_current <= 16'($urandom);
      @(posedge i_ref_clk);
      rx = '{UNIMP_U16, UNIMP_S16, SF_VOLTAGE, SF_LIMIT, SF_TOTAL_CUR, UNIMP_U16,
             i_dc_voltage, i_charge_limit, i_discharge_limit, i_dc_current};
      foreach (ra[k]) acc(1'b0, ra[k], 16'h0, 1'b1, 1'b1, 1'b0, rx[k]);
    end
    acc(1'b0, ADDR_PWR_REQ_HI, 16'h0, 1'b1, 1'b0, 1'b0, UNIMP_S32[31:16]);
    acc(1'b0, ADDR_PWR_REQ_LO, 16'h0, 1'b0, 1'b1, 1'b0, UNIMP_S32[15:0]);
    acc(1'b0, ADDR_STR_EVT2_HI, 16'h0, 1'b1, 1'b0, 1'b0, UNIMP_U32[31:16]);
    acc(1'b0, ADDR_STR_EVT2_LO, 16'h0, 1'b0, 1'b1, 1'b0, UNIMP_U32[15:0]);
    acc(1'b0, ADDR_CYCLE_CT_LO, 16'h0, 1'b1, 1'b1, 1'b1, 16'h0);
    acc(1'b0, ADDR_CYCLE_CT_HI, 16'h0, 1'b1, 1'b1, 1'b1, 16'h0);
    acc(1'b1, ADDR_UNIMP_S16_A, 16'h1234, 1'b1, 1'b1, 1'b1, 16'h0);
    acc(1'b0, MAP_LAST + 16'h1, 16'h0, 1'b1, 1'b1, 1'b1, 16'h0);
    u_mst.beat();
    u_mst.beat();
    acc(1'b0, ADDR_CONTROLLER_HB, 16'h0, 1'b1, 1'b1, 1'b0, 16'h0000);
    u_mst.xfer(1'b0, ADDR_DEVICE_HB, 16'h0, 1'b1, 1'b1);
    hb_first = u_mst.got_data;
    // polls about three times per tick; the two heartbeat reads stay 61 edges apart
    repeat (9) begin
      repeat (4) @(posedge i_ref_clk);
      acc(1'b0, ADDR_FAULT_BITS, 16'h0, 1'b1, 1'b1, 1'b0, 16'h0);
    end
    repeat (5) @(posedge i_ref_clk);
    acc(1'b0, ADDR_DEVICE_HB, 16'h0, 1'b1, 1'b1, 1'b0, hb_after(hb_first, 61));
    chb("stack_fault", 1'b0, o_stack_fault);
    @(posedge i_ref_clk);
    i_precharge_cfg <= 1'b1;
    acc(1'b1, ADDR_STACK_CMD, CMD_CONNECT, 1'b1, 1'b1, 1'b0, 16'h0);
    settle(1);
    chb("precharge_en", 1'b1, o_precharge_en);
    chb("contactor", 1'b0, o_contactor_close);
    @(posedge i_ref_clk);
    i_precharge_done <= 1'b1;
    settle(2);
    chb("contactor", 1'b1, o_contactor_close);
    acc(1'b0, ADDR_STACK_CMD, 16'h0, 1'b1, 1'b1, 1'b0, CMD_CONNECT);
    acc(1'b1, ADDR_STACK_CMD, 16'h0002, 1'b1, 1'b1, 1'b1, 16'h0);
    acc(1'b1, ADDR_STACK_CMD, CMD_DISCONNECT, 1'b1, 1'b1, 1'b0, 16'h0);
    settle(1);
    chb("contactor", 1'b0, o_contactor_close);
    @(posedge i_ref_clk);
    i_wdog_enable <= 1'b1;
    u_mst.beat();
    acc(1'b1, ADDR_STACK_CMD, CMD_CONNECT, 1'b1, 1'b1, 1'b0, 16'h0);
    settle(3);
    chb("contactor", 1'b1, o_contactor_close);
    settle(3 * TICKS);
    chb("stack_fault", 1'b1, o_stack_fault);
    chb("contactor", 1'b0, o_contactor_close);
    u_mst.beat();
    settle(1);
    chb("stack_fault", 1'b0, o_stack_fault);
    @(posedge i_ref_clk);
    i_wdog_enable <= 1'b0;
    i_alarm_cond <= 16'h0018;
    @(posedge i_ref_clk);
    i_alarm_cond <= 16'h0010;
    acc(1'b0, ADDR_FAULT_BITS, 16'h0, 1'b1, 1'b1, 1'b0, 16'h0019);
    acc(1'b1, ADDR_ALARM_CLEAR, ALARM_CLEAR_VAL, 1'b1, 1'b1, 1'b0, 16'h0);
    settle(1);
    chk("alarm_latched", 16'h0010, o_alarm_latched);
    conn(1'b0, 1'b1);
    conn(1'b0, 1'b0);
    @(posedge i_ref_clk);
    i_conn_close <= 1'b1;
    @(posedge i_ref_clk);
    i_conn_close <= 1'b0;
    conn(1'b0, 1'b1);
    conn(1'b1, 1'b0);
    @(posedge i_ref_clk);
    i_grid_variant <= 1'b1;
    conn(1'b1, 1'b1);
    @(posedge i_ref_clk);
    i_req_port_ro <= 1'b1;
    acc(1'b1, ADDR_CONTROLLER_HB, 16'h0005, 1'b1, 1'b1, 1'b1, 16'h0);
    test_done();
  end
endmodule // battery_modbus_point_responder_tb_top

// >>> verification/bmr_site_master.sv
// Purpose: site controller model, master of the register port
// Assumes: one register per call; the answer comes one cycle after it is taken
// Notes:   released address and data show inverted values, never the old ones
`timescale 1ns/100ps
module bmr_site_master (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_error,
  input  wire logic [15:0] i_rsp_data,
  output logic             o_req_valid,
  output logic             o_req_write,
  output logic [15:0]      o_req_addr,
  output logic [15:0]      o_req_wdata,
  output logic             o_req_first,
  output logic             o_req_last
);
  logic        got_valid;
  logic        got_error;
  logic [15:0] got_data;
  // starts near the top so the second beat wraps
  logic [15:0] hb_reg = 16'hfffe;
  initial begin
    {o_req_valid, o_req_write, o_req_first, o_req_last} = 4'h0;
    o_req_addr = 16'h0000;
    o_req_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [15:0] a, d, input logic f, l);
    @(posedge i_ref_clk);
    o_req_valid <= 1'b1;
    o_req_write <= w;
    o_req_addr <= a;
    o_req_wdata <= d;
    {o_req_first, o_req_last} <= {f, l};
    @(posedge i_ref_clk);
    o_req_valid <= 1'b0;
    o_req_addr <= ~a;
    o_req_wdata <= ~d;
    #1;
    got_valid = i_rsp_valid;
    got_error = i_rsp_error;
    got_data = i_rsp_data;
  endtask
  task automatic beat();
    hb_reg = hb_reg + 16'h0001;
    xfer(1'b1, bmr_pkg::ADDR_CONTROLLER_HB, hb_reg, 1'b1, 1'b1);
  endtask
endmodule // bmr_site_master
